// ---- rtl/monitor_eeprom_ctrl.v ----
// eeprom control, factory test, identity and interrupt mask registers
// ------------------------------------------------------------------
// What this block does
// - writing control bit 0 as one puts the eeprom in read mode
// - writing control bit 1 as one puts the eeprom in program mode
// - writing control bit 2 as one puts the eeprom in erase mode
// - bit 3 blocks program and erase; write-once, cleared by reset only
// - with bit 7 set, scl may be held low while data cannot be taken
// - read-only 8-bit register holds a fixed maker identity code
// - revision low nibble is minor revision, first revision reads zero
// - revision high nibble is a fixed device generation code
// - first mask register suppresses temperature and supply interrupts
// - second mask register bit n suppresses analog input n interrupts
// - third mask register bit n suppresses fan tach n interrupts
// - mask and eeprom control registers reset to zero
// ------------------------------------------------------------------
`include "monitor_eeprom_ctrl_regs.vh"
`default_nettype none

module monitor_eeprom_ctrl (
    input wire clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    output wire [7:0] reg_rd_data,
    output wire reg_rd_valid,
    output wire ee_read_mode,
    output wire ee_program_mode,
    output wire ee_erase_mode,
    output wire ee_protect,
    output wire [2:0] ee_test_mode,
    output wire ee_protect_violation,
    input wire ee_busy,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_n,
    input wire [7:0] temp_supply_event,
    input wire [7:0] analog_in_event,
    input wire [7:0] fan_tach_event,
    output wire [7:0] temp_supply_irq,
    output wire [7:0] analog_in_irq,
    output wire [7:0] fan_tach_irq
);

    // ------------------------------------------------------------------
    // mode state machine codes
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_PROGRAM = 4'h4;
    localparam [3:0] ST_ERASE = 4'h8;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    reg ctl_read_ff;
    reg ctl_program_ff;
    reg ctl_erase_ff;
    reg ctl_protect_ff;
    reg [2:0] ctl_test_ff;
    reg ctl_stretch_ff;
    reg [3:0] mode_ff;
    reg [3:0] nxt_mode;
    reg [7:0] rd_data_ff;
    reg [7:0] nxt_rd_data;
    reg rd_valid_ff;
    reg violation_ff;
    reg nxt_violation;
    reg viol_seen_ff;
    reg scl_out_ff;
    reg scl_oe_n_ff;
    reg nxt_scl_oe_n;
    reg [7:0] temp_supply_irq_ff;
    reg [7:0] analog_in_irq_ff;
    reg [7:0] fan_tach_irq_ff;
    wire wr_ctl;
    wire wr_test_one;
    wire wr_test_two;
    wire wr_mask_ts;
    wire wr_mask_ai;
    wire wr_mask_ft;
    wire [7:0] ctl_value;
    wire [7:0] revision_value;
    wire [7:0] test_one_value;
    wire [7:0] test_two_value;
    wire [7:0] mask_ts_value;
    wire [7:0] mask_ai_value;
    wire [7:0] mask_ft_value;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign wr_ctl = reg_wr_en && (reg_addr == `OFS_EEPROM_CONTROL);
    assign wr_test_one = reg_wr_en && (reg_addr == `OFS_FACTORY_TEST_ONE);
    assign wr_test_two = reg_wr_en && (reg_addr == `OFS_FACTORY_TEST_TWO);
    assign wr_mask_ts = reg_wr_en && (reg_addr == `OFS_IRQ_MASK_TEMP_SUPPLY);
    assign wr_mask_ai = reg_wr_en && (reg_addr == `OFS_IRQ_MASK_ANALOG_IN);
    assign wr_mask_ft = reg_wr_en && (reg_addr == `OFS_IRQ_MASK_FAN_TACH);

    // ------------------------------------------------------------------
    // eeprom control register
    // ------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_read_ff <= 1'b0;
            ctl_program_ff <= 1'b0;
            ctl_erase_ff <= 1'b0;
            ctl_test_ff <= 3'h0;
            ctl_stretch_ff <= 1'b0;
        end else if (wr_ctl) begin
            ctl_read_ff <= reg_wr_data[`EE_READ_BIT];
            ctl_program_ff <= reg_wr_data[`EE_PROGRAM_BIT];
            ctl_erase_ff <= reg_wr_data[`EE_ERASE_BIT];
            ctl_test_ff <= reg_wr_data[`EE_TEST_MSB:`EE_TEST_LSB];
            ctl_stretch_ff <= reg_wr_data[`EE_STRETCH_BIT];
        end
    end

    // sticky: once set no write can clear it, only reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_protect_ff <= 1'b0;
        end else if (wr_ctl && reg_wr_data[`EE_PROTECT_BIT]) begin
            ctl_protect_ff <= 1'b1;
        end
    end

    assign ctl_value = {ctl_stretch_ff, ctl_test_ff, ctl_protect_ff,
        ctl_erase_ff, ctl_program_ff, ctl_read_ff};

    // ------------------------------------------------------------------
    // eeprom mode selection
    // ------------------------------------------------------------------
    // several bits at once is a host fault; read wins so that a protected
    // part never lands in a destructive mode by accident
    always @* begin
        nxt_mode = ST_IDLE;
        nxt_violation = 1'b0;
        if (ctl_read_ff) begin
            nxt_mode = ST_READ;
        end else if (ctl_program_ff && !ctl_protect_ff) begin
            nxt_mode = ST_PROGRAM;
        end else if (ctl_erase_ff && !ctl_protect_ff) begin
            nxt_mode = ST_ERASE;
        end
        case (mode_ff)
            ST_IDLE: begin
                nxt_violation = ctl_protect_ff &&
                    (ctl_program_ff || ctl_erase_ff) && !ctl_read_ff;
            end
            ST_READ: begin
                nxt_violation = 1'b0;
            end
            ST_PROGRAM: begin
                nxt_violation = ctl_protect_ff && ctl_program_ff;
            end
            ST_ERASE: begin
                nxt_violation = ctl_protect_ff && ctl_erase_ff;
            end
            default: begin
                nxt_mode = ST_IDLE;
                nxt_violation = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= ST_IDLE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------------
    // protect violation pulse
    // ------------------------------------------------------------------
    // edge of the blocked request, so a stored program bit pulses only once
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            violation_ff <= 1'b0;
            viol_seen_ff <= 1'b0;
        end else begin
            violation_ff <= nxt_violation && !viol_seen_ff;
            viol_seen_ff <= nxt_violation;
        end
    end

    assign ee_read_mode = mode_ff[1];
    assign ee_program_mode = mode_ff[2];
    assign ee_erase_mode = mode_ff[3];
    assign ee_protect = ctl_protect_ff;
    assign ee_test_mode = ctl_test_ff;
    assign ee_protect_violation = violation_ff;

    // ------------------------------------------------------------------
    // serial clock stretching
    // ------------------------------------------------------------------
    // only grab scl once the host has pulled it low, never mid-high phase
    always @* begin
        nxt_scl_oe_n = 1'b1;
        if (ctl_stretch_ff && ee_busy && (!scl_in || !scl_oe_n_ff)) begin
            nxt_scl_oe_n = 1'b0;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_out_ff <= 1'b0;
            scl_oe_n_ff <= 1'b1;
        end else begin
            scl_out_ff <= 1'b0;
            scl_oe_n_ff <= nxt_scl_oe_n;
        end
    end

    assign scl_out = scl_out_ff;
    assign scl_oe_n = scl_oe_n_ff;

    // ------------------------------------------------------------------
    // factory test and mask registers
    // ------------------------------------------------------------------
    byte_reg #(.RESET_VALUE(`RST_FACTORY_TEST)) u_test_one (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_test_one),
        .wr_data(reg_wr_data),
        .value(test_one_value)
    );

    byte_reg #(.RESET_VALUE(`RST_FACTORY_TEST)) u_test_two (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_test_two),
        .wr_data(reg_wr_data),
        .value(test_two_value)
    );

    byte_reg #(.RESET_VALUE(`RST_IRQ_MASK)) u_mask_ts (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_mask_ts),
        .wr_data(reg_wr_data),
        .value(mask_ts_value)
    );

    byte_reg #(.RESET_VALUE(`RST_IRQ_MASK)) u_mask_ai (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_mask_ai),
        .wr_data(reg_wr_data),
        .value(mask_ai_value)
    );

    byte_reg #(.RESET_VALUE(`RST_IRQ_MASK)) u_mask_ft (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_mask_ft),
        .wr_data(reg_wr_data),
        .value(mask_ft_value)
    );

    // ------------------------------------------------------------------
    // interrupt masking
    // ------------------------------------------------------------------
    // one cycle of latency, so outputs stay glitch free
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_supply_irq_ff <= 8'h00;
            analog_in_irq_ff <= 8'h00;
            fan_tach_irq_ff <= 8'h00;
        end else begin
            temp_supply_irq_ff <= temp_supply_event & ~mask_ts_value;
            analog_in_irq_ff <= analog_in_event & ~mask_ai_value;
            fan_tach_irq_ff <= fan_tach_event & ~mask_ft_value;
        end
    end

    assign temp_supply_irq = temp_supply_irq_ff;
    assign analog_in_irq = analog_in_irq_ff;
    assign fan_tach_irq = fan_tach_irq_ff;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    assign revision_value = {`GENERATION_CODE, `MINOR_REVISION_CODE};

    always @* begin
        nxt_rd_data = `UNMAPPED_READ;
        case (reg_addr)
            `OFS_EEPROM_CONTROL: begin
                nxt_rd_data = ctl_value;
            end
            `OFS_FACTORY_TEST_ONE: begin
                nxt_rd_data = test_one_value;
            end
            `OFS_FACTORY_TEST_TWO: begin
                nxt_rd_data = test_two_value;
            end
            `OFS_MAKER_IDENTITY: begin
                nxt_rd_data = `MAKER_IDENTITY_CODE;
            end
            `OFS_SILICON_REVISION: begin
                nxt_rd_data = revision_value;
            end
            `OFS_IRQ_MASK_TEMP_SUPPLY: begin
                nxt_rd_data = mask_ts_value;
            end
            `OFS_IRQ_MASK_ANALOG_IN: begin
                nxt_rd_data = mask_ai_value;
            end
            `OFS_IRQ_MASK_FAN_TACH: begin
                nxt_rd_data = mask_ft_value;
            end
            default: begin
                nxt_rd_data = `UNMAPPED_READ;
            end
        endcase
    end

    // data holds until the next read strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign reg_rd_data = rd_data_ff;
    assign reg_rd_valid = rd_valid_ff;

endmodule

`default_nettype wire

// ---- rtl/monitor_eeprom_ctrl_regs.vh ----
// offsets, field positions and reset values of the monitor register bank
`ifndef MONITOR_EEPROM_CTRL_REGS_VH
`define MONITOR_EEPROM_CTRL_REGS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_EEPROM_CONTROL 8'h13
`define OFS_FACTORY_TEST_ONE 8'h14
`define OFS_FACTORY_TEST_TWO 8'h15
`define OFS_MAKER_IDENTITY 8'h16
`define OFS_SILICON_REVISION 8'h17
`define OFS_IRQ_MASK_TEMP_SUPPLY 8'h18
`define OFS_IRQ_MASK_ANALOG_IN 8'h19
`define OFS_IRQ_MASK_FAN_TACH 8'h1A

// ------------------------------------------------------------------
// eeprom control fields
// ------------------------------------------------------------------
`define EE_READ_BIT 0
`define EE_PROGRAM_BIT 1
`define EE_ERASE_BIT 2
`define EE_PROTECT_BIT 3
`define EE_TEST_LSB 4
`define EE_TEST_MSB 6
`define EE_STRETCH_BIT 7

// ------------------------------------------------------------------
// reset and fixed values
// ------------------------------------------------------------------
`define RST_EEPROM_CONTROL 8'h00
`define RST_FACTORY_TEST 8'h00
`define RST_IRQ_MASK 8'h00
`define UNMAPPED_READ 8'h00
// arbitrary identity values, not any real part
`define MAKER_IDENTITY_CODE 8'h5A
`define GENERATION_CODE 4'hA
`define MINOR_REVISION_CODE 4'h0

`endif

// ---- rtl/byte_reg.v ----
// one 8-bit software register with write strobe and reset value
`default_nettype none

module byte_reg #(
    parameter [7:0] RESET_VALUE = 8'h00
) (
    input wire clk,
    input wire reset_n,
    input wire wr_en,
    input wire [7:0] wr_data,
    output wire [7:0] value
);

    reg [7:0] value_ff;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            value_ff <= RESET_VALUE;
        end else if (wr_en) begin
            value_ff <= wr_data;
        end
    end

    assign value = value_ff;

endmodule

`default_nettype wire

// ---- rtl/placeholder_unused_never.v ----
`default_nettype none
`default_nettype wire

// ---- testbench/monitor_eeprom_ctrl_monitor.sv ----
// assertion checker on the register bank ports
`include "monitor_eeprom_ctrl_regs.vh"
`default_nettype none
module monitor_eeprom_ctrl_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic ee_read_mode,
    input wire logic ee_program_mode,
    input wire logic ee_erase_mode,
    input wire logic ee_protect,
    input wire logic ee_busy,
    input wire logic scl_oe_n,
    input wire logic [7:0] fan_tach_event,
    input wire logic [7:0] fan_tach_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence ctl_wr;
        reg_wr_en && reg_addr == `OFS_EEPROM_CONTROL;
    endsequence
    // mode state lags the control register by one more edge
    sequence mode_on(m);
        ##1 m;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    read_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe gave no valid");
    ident_read_a: assert property (reg_rd_en &&
        reg_addr == `OFS_MAKER_IDENTITY |=>
        reg_rd_data == `MAKER_IDENTITY_CODE)
        else $error("identity read wrong");
    revision_read_a: assert property (reg_rd_en &&
        reg_addr == `OFS_SILICON_REVISION |=>
        reg_rd_data == {`GENERATION_CODE, `MINOR_REVISION_CODE})
        else $error("revision read wrong");
    read_mode_a: assert property (ctl_wr ##0 reg_wr_data[0]
        |=> mode_on(ee_read_mode))
        else $error("read mode not entered");
    program_mode_a: assert property (ctl_wr ##0
        (reg_wr_data[3:0] == 4'h2 && !ee_protect)
        |=> mode_on(ee_program_mode))
        else $error("program mode not entered");
    erase_mode_a: assert property (ctl_wr ##0
        (reg_wr_data[3:0] == 4'h4 && !ee_protect)
        |=> mode_on(ee_erase_mode))
        else $error("erase mode not entered");
    protect_hold_a: assert property (ee_protect |=>
        ee_protect && !ee_program_mode && !ee_erase_mode)
        else $error("protect dropped or bypassed");
    stretch_cause_a: assert property (!scl_oe_n |-> $past(ee_busy))
        else $error("clock held low while not busy");
    fan_mask_a: assert property (
        (fan_tach_irq & ~$past(fan_tach_event)) == 8'h00)
        else $error("fan interrupt without event");
    reset_clear_a: assert property ($rose(reset_n) |->
        !ee_protect && !ee_read_mode && scl_oe_n && fan_tach_irq == 8'h00)
        else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ---- testbench/host_scl_model.sv ----
// host side of the serial clock wire with its pull-up
`default_nettype none
module host_scl_model (
    input wire logic clk,
    input wire logic frame,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    output wire logic scl_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_scl = 1'b1;
    // clock stands high between frames; a wire held low stalls the host
    always @(posedge clk) begin
        if (!frame) begin
            host_scl <= 1'b1;
        end else if (!host_scl || scl_in) begin
            host_scl <= ~host_scl;
        end
    end
    // wired-and: either party may pull low
    assign scl_in = host_scl & (scl_oe_n | scl_out);
endmodule
`default_nettype wire

// ---- testbench/monitor_eeprom_ctrl_and_irq_masks_bench.sv ----
// self-checking bench for the monitor register bank
`include "monitor_eeprom_ctrl_regs.vh"
`default_nettype none
module monitor_eeprom_ctrl_and_irq_masks_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic busy = 1'b0, frame = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ev = 8'h00;
    wire [7:0] rdata, ts_irq, ai_irq, ft_irq;
    wire rvalid, rmode, pmode, emode, prot, scl_in, scl_out, scl_oe_n;
    wire viol;
    wire [2:0] tmode;
    wire [7:0] modes = {prot, tmode, viol, emode, pmode, rmode};
    logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, `MAKER_IDENTITY_CODE,
        {`GENERATION_CODE, `MINOR_REVISION_CODE}, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [3] = '{8'hA5, 8'h3C, 8'h81};
    int n_mismatch = 0, tests_run = 0;
    always #50 clk = ~clk;
    monitor_eeprom_ctrl DUT (.clk(clk), .reset_n(reset_n), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
        .reg_rd_data(rdata), .reg_rd_valid(rvalid), .ee_read_mode(rmode),
        .ee_program_mode(pmode), .ee_erase_mode(emode), .ee_protect(prot),
        .ee_test_mode(tmode), .ee_protect_violation(viol), .ee_busy(busy),
        .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .temp_supply_event(ev), .analog_in_event(ev), .fan_tach_event(ev),
        .temp_supply_irq(ts_irq), .analog_in_irq(ai_irq),
        .fan_tach_irq(ft_irq));
    host_scl_model u_host (.clk(clk), .frame(frame), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .scl_in(scl_in));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    task automatic wait_chk(input int n, input logic [7:0] got_sel,
        input logic [7:0] exp);
        repeat (n) @(posedge clk);
        #1;
        case (got_sel)
            8'h00: chk(modes, exp);
            8'h01: chk({6'h00, scl_out, scl_oe_n}, exp);
            default: chk(ft_irq, exp);
        endcase
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // 0x1B is unmapped and reads zero
        for (int i = 0; i < 9; i++) begin
            rd(8'h13 + i[7:0], rst_tab[i]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h18 + i[7:0], mk[i]);
        end
        wr(`OFS_MAKER_IDENTITY, 8'hFF);
        wr(`OFS_SILICON_REVISION, 8'hFF);
        rd(`OFS_MAKER_IDENTITY, rst_tab[3]);
        rd(`OFS_SILICON_REVISION, rst_tab[4]);
        for (int i = 0; i < 3; i++) begin
            rd(8'h18 + i[7:0], mk[i]);
        end
        @(posedge clk);
        ev <= 8'hFF;
        wait_chk(2, 8'h02, ~mk[2]);
        chk(ts_irq, ~mk[0]);
        chk(ai_irq, ~mk[1]);
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_EEPROM_CONTROL, 8'h01 << i);
            wait_chk(1, 8'h00, 8'h01 << i);
        end
        wr(`OFS_EEPROM_CONTROL, 8'h80);
        frame <= 1'b1;
        busy <= 1'b1;
        wait_chk(4, 8'h01, 8'h00);
        @(posedge clk);
        busy <= 1'b0;
        wait_chk(2, 8'h01, 8'h01);
        wr(`OFS_EEPROM_CONTROL, 8'h00);
        busy <= 1'b1;
        wait_chk(4, 8'h01, 8'h01);
        @(posedge clk);
        busy <= 1'b0;
        frame <= 1'b0;
        wr(`OFS_EEPROM_CONTROL, 8'h08);
        wr(`OFS_EEPROM_CONTROL, 8'h02);
        // protect set, violation pulse up, modes all off
        wait_chk(1, 8'h00, 8'h88);
        rd(`OFS_EEPROM_CONTROL, 8'h0A);
        // the pulse must not repeat while the program bit stays stored
        chk(modes, 8'h80);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFS_EEPROM_CONTROL, 8'h00);
        chk(modes, 8'h00);
        rd(`OFS_IRQ_MASK_FAN_TACH, 8'h00);
        wait_chk(1, 8'h02, 8'hFF);
        complete_run();
    end
    // the tests need well under 200 cycles
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
bind monitor_eeprom_ctrl monitor_eeprom_ctrl_checker u_checker (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .ee_read_mode(ee_read_mode),
    .ee_program_mode(ee_program_mode), .ee_erase_mode(ee_erase_mode),
    .ee_protect(ee_protect), .ee_busy(ee_busy), .scl_oe_n(scl_oe_n),
    .fan_tach_event(fan_tach_event), .fan_tach_irq(fan_tach_irq));
`default_nettype wire
